// [rtl/cog_special_registers.sv]
`timescale 1ns/100ps
`include "cog_sreg_regs.svh"
module cog_special_registers (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire cog_sreg_pkg::reg_addr_t src_addr,
  input  wire cog_sreg_pkg::reg_addr_t dst_addr,
  input  wire logic                   wr_en,
  input  wire cog_sreg_pkg::reg_addr_t wr_addr,
  input  wire cog_sreg_pkg::word_t    wr_data,
  output logic                        src_hit,
  output cog_sreg_pkg::word_t         src_data,
  output logic                        dst_hit,
  output cog_sreg_pkg::word_t         dst_data,
  input  wire logic                   launch_load,
  input  wire cog_sreg_pkg::word_t    launch_value,
  input  wire cog_sreg_pkg::word_t    pins_a_in,
  output cog_sreg_pkg::word_t         pins_a_out,
  output cog_sreg_pkg::word_t         pins_a_oe,
  output cog_sreg_pkg::word_t         counter_a_control,
  output cog_sreg_pkg::word_t         counter_b_control,
  output cog_sreg_pkg::word_t         counter_a_increment,
  output cog_sreg_pkg::word_t         counter_b_increment,
  input  wire cog_sreg_pkg::word_t    phase_a_live,
  input  wire cog_sreg_pkg::word_t    phase_b_live,
  output logic                        phase_a_load,
  output logic                        phase_b_load,
  output cog_sreg_pkg::word_t         phase_load_value,
  output cog_sreg_pkg::word_t         video_config,
  output cog_sreg_pkg::word_t         video_scale,
  output cog_sreg_pkg::word_t         tick_count
);
  import cog_sreg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  word_t launch_r;
  word_t tick_r;
  word_t pin_meta_r;
  word_t pin_sync_r;
  word_t out_a_r;
  word_t dir_a_r;
  word_t ctl_r [0:1];
  word_t inc_r [0:1];
  word_t vid_cfg_r;
  word_t vid_scl_r;
  word_t src_data_r;
  word_t dst_live_r;
  logic  dst_shadow_r;
  logic  ph_a_load_r;
  logic  ph_b_load_r;
  word_t ph_value_r;
  word_t shadow_q;
  logic  wr_hit;
  slot_t wr_slot;
  slot_t dst_slot;

  function automatic logic is_special(input reg_addr_t a);
    is_special = (a[8:4] == `SREG_BASE);
  endfunction

  function automatic slot_t slot_of(input reg_addr_t a);
    slot_of = a[3:0];
  endfunction

  // destination read of these slots gives the stored copy, never live state
  function automatic logic uses_shadow(input slot_t s);
    uses_shadow = (s == `SLOT_LAUNCH) || (s == `SLOT_TICK) || (s == `SLOT_A_IN) ||
                  (s == `SLOT_CA_PH) || (s == `SLOT_CB_PH);
  endfunction

  // live contents of a slot as seen by instructions
  function automatic word_t live_value(input slot_t s, input word_t ph_a,
                                       input word_t ph_b);
    word_t v;
    v = `SREG_RST;
    unique case (s)
      `SLOT_LAUNCH:  v = launch_r;
      `SLOT_TICK:    v = tick_r;
      `SLOT_A_IN:    v = pin_sync_r;
      `SLOT_A_OUT:   v = out_a_r;
      `SLOT_A_DIR:   v = dir_a_r;
      `SLOT_CA_CTL:  v = ctl_r[0];
      `SLOT_CB_CTL:  v = ctl_r[1];
      `SLOT_CA_INC:  v = inc_r[0];
      `SLOT_CB_INC:  v = inc_r[1];
      `SLOT_CA_PH:   v = ph_a;
      `SLOT_CB_PH:   v = ph_b;
      `SLOT_VID_CFG: v = vid_cfg_r;
      `SLOT_VID_SCL: v = vid_scl_r;
      default:       v = `SREG_RST; // port b slots read as zero
    endcase
    live_value = v;
  endfunction

  // address decode for the sixteen-slot bank
  assign wr_hit   = wr_en && is_special(wr_addr);
  assign wr_slot  = slot_of(wr_addr);
  assign dst_slot = slot_of(dst_addr);
  assign src_hit  = is_special(src_addr);
  assign dst_hit  = is_special(dst_addr);

  // free-running tick, wraps through zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= `TICK_RST;
    end else begin
      tick_r <= tick_r + `TICK_STEP;
    end
  end

  // launch argument only changes on a processor start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      launch_r <= `SREG_RST;
    end else if (launch_load) begin
      launch_r <= launch_value;
    end
  end

  // two-stage pin synchroniser; only the second stage is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= `SREG_RST;
      pin_sync_r <= `SREG_RST;
    end else begin
      pin_meta_r <= pins_a_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // writable slots; input, tick and launch have no write path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_a_r  <= `SREG_RST;
      dir_a_r  <= `SREG_RST;
      ctl_r[0] <= `SREG_RST;
      ctl_r[1] <= `SREG_RST;
      inc_r[0] <= `SREG_RST;
      inc_r[1] <= `SREG_RST;
      vid_cfg_r <= `SREG_RST;
      vid_scl_r <= `SREG_RST;
    end else if (wr_hit) begin
      unique case (wr_slot)
        `SLOT_A_OUT:   out_a_r  <= wr_data;
        `SLOT_A_DIR:   dir_a_r  <= wr_data;
        `SLOT_CA_CTL:  ctl_r[0] <= wr_data;
        `SLOT_CB_CTL:  ctl_r[1] <= wr_data;
        `SLOT_CA_INC:  inc_r[0] <= wr_data;
        `SLOT_CB_INC:  inc_r[1] <= wr_data;
        `SLOT_VID_CFG: vid_cfg_r <= wr_data;
        `SLOT_VID_SCL: vid_scl_r <= wr_data;
        default: ; // read-only and reserved slots drop the write
      endcase
    end
  end

  // phase writes go to the counter unit as a one-cycle load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_a_load_r <= 1'b0;
      ph_b_load_r <= 1'b0;
      ph_value_r  <= `SREG_RST;
    end else begin
      ph_a_load_r <= wr_hit && (wr_slot == `SLOT_CA_PH);
      ph_b_load_r <= wr_hit && (wr_slot == `SLOT_CB_PH);
      if (wr_hit) begin
        ph_value_r <= wr_data;
      end
    end
  end

  // copy of every write, used for destination reads of restricted slots
  sreg_shadow_mem #(
    .WIDTH     (32),
    .ADDR_BITS (4)
  ) u_shadow (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (wr_hit),
    .wr_addr (wr_slot),
    .wr_data (wr_data),
    .rd_addr (dst_slot),
    .rd_data (shadow_q)
  );

  // source read: live value, one cycle after the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_data_r <= `SREG_RST;
    end else if (src_hit) begin
      src_data_r <= live_value(slot_of(src_addr), phase_a_live, phase_b_live);
    end else begin
      src_data_r <= `SREG_RST;
    end
  end

  // destination read: live for plain slots, stored copy for restricted ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dst_live_r   <= `SREG_RST;
      dst_shadow_r <= 1'b0;
    end else begin
      dst_shadow_r <= dst_hit && uses_shadow(dst_slot);
      dst_live_r   <= dst_hit ? live_value(dst_slot, `SREG_RST, `SREG_RST) : `SREG_RST;
    end
  end

  // selection between two registers; kept as a mux to save a pipeline stage
  assign dst_data            = dst_shadow_r ? shadow_q : dst_live_r;
  assign src_data            = src_data_r;
  assign pins_a_out          = out_a_r;
  assign pins_a_oe           = dir_a_r;
  assign counter_a_control   = ctl_r[0];
  assign counter_b_control   = ctl_r[1];
  assign counter_a_increment = inc_r[0];
  assign counter_b_increment = inc_r[1];
  assign phase_a_load        = ph_a_load_r;
  assign phase_b_load        = ph_b_load_r;
  assign phase_load_value    = ph_value_r;
  assign video_config        = vid_cfg_r;
  assign video_scale         = vid_scl_r;
  assign tick_count          = tick_r;

  // checks
  localparam reg_addr_t A_TICK   = {`SREG_BASE, `SLOT_TICK};
  localparam reg_addr_t A_LAUNCH = {`SREG_BASE, `SLOT_LAUNCH};
  localparam reg_addr_t A_IN     = {`SREG_BASE, `SLOT_A_IN};
  localparam reg_addr_t A_OUT    = {`SREG_BASE, `SLOT_A_OUT};
  localparam reg_addr_t A_DIR    = {`SREG_BASE, `SLOT_A_DIR};
  localparam reg_addr_t A_BOUT   = {`SREG_BASE, `SLOT_B_OUT};
  localparam reg_addr_t A_PHA    = {`SREG_BASE, `SLOT_CA_PH};
  localparam reg_addr_t A_VID    = {`SREG_BASE, `SLOT_VID_CFG};

  property p_outside_bank;
    !is_special(src_addr) |=> src_data == `SREG_RST;
  endproperty
  a_outside_bank: assert property (p_outside_bank) else $error("miss read not zero");
  property p_plain_slot;
    (wr_en && wr_addr == A_VID) ##1 (src_addr == A_VID && !wr_en)
      |=> src_data == $past(wr_data, 2);
  endproperty
  a_plain_slot: assert property (p_plain_slot) else $error("video readback wrong");
  property p_ro_tick_write;
    (wr_en && wr_addr == A_TICK) |=> tick_count == $past(tick_count) + `TICK_STEP;
  endproperty
  a_ro_tick_write: assert property (p_ro_tick_write) else $error("tick write taken");
  property p_phase_dst;
    (wr_en && wr_addr == A_PHA) ##1 (dst_addr == A_PHA && !wr_en)
      |=> dst_data == $past(wr_data, 2);
  endproperty
  a_phase_dst: assert property (p_phase_dst) else $error("phase dest not copy");
  property p_phase_src;
    src_addr == A_PHA |=> src_data == $past(phase_a_live);
  endproperty
  a_phase_src: assert property (p_phase_src) else $error("phase source read not live");
  property p_whole_words;
    (wr_en && (wr_addr == A_OUT || wr_addr == A_DIR)) |=>
      (pins_a_out == ($past(wr_addr) == A_OUT ? $past(wr_data) : $past(pins_a_out))) &&
      (pins_a_oe == ($past(wr_addr) == A_DIR ? $past(wr_data) : $past(pins_a_oe)));
  endproperty
  a_whole_words: assert property (p_whole_words) else $error("port word write wrong");
  property p_pin_read;
    src_addr == A_IN |=> src_data == $past(pins_a_in, 3);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read not three cycles old");
  property p_tick_read;
    src_addr == A_TICK |=> src_data == $past(tick_count);
  endproperty
  a_tick_read: assert property (p_tick_read) else $error("tick read wrong");
  property p_launch;
    launch_load ##1 (src_addr == A_LAUNCH && !launch_load) |=> src_data == $past(launch_value, 2);
  endproperty
  a_launch: assert property (p_launch) else $error("launch argument read wrong");
  property p_reserved;
    src_addr == A_BOUT |=> src_data == `SREG_RST;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved slot not zero");
  // start only once reset is seen released, the release edge itself does not count
  property p_tick_step;
    rst_n |=> tick_count == $past(tick_count) + `TICK_STEP;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("tick did not step");

  property p_cov_phase;
    (wr_en && wr_addr == A_PHA) ##1 dst_addr == A_PHA;
  endproperty
  c_cov_phase: cover property (p_cov_phase);
  property p_cov_launch;
    launch_load ##1 src_addr == A_LAUNCH;
  endproperty
  c_cov_launch: cover property (p_cov_launch);
  property p_cov_dir;
    wr_en && wr_addr == A_DIR;
  endproperty
  c_cov_dir: cover property (p_cov_dir);
endmodule // cog_special_registers

// [rtl/cog_sreg_regs.svh]
// Functional notes
// - sixteen special slots in every processor
// - unrestricted slots act as normal source/destination
// - input, tick, launch slots ignore writes
// - phase destination read gives no live value
// - direction/output accessed as whole 32-bit words
// - input slot returns all 32 pins
// - read-only 32-bit shared system tick count
// - launch argument fixed at start, read-only
// - port b slots reserved, no pin behaviour
`ifndef COG_SREG_REGS_SVH
`define COG_SREG_REGS_SVH

// upper five bits of a 9-bit register address that select the special bank
`define SREG_BASE        5'h1f

// slot index within the special bank
`define SLOT_LAUNCH      4'h0
`define SLOT_TICK        4'h1
`define SLOT_A_IN        4'h2
`define SLOT_B_IN        4'h3
`define SLOT_A_OUT       4'h4
`define SLOT_B_OUT       4'h5
`define SLOT_A_DIR       4'h6
`define SLOT_B_DIR       4'h7
`define SLOT_CA_CTL      4'h8
`define SLOT_CB_CTL      4'h9
`define SLOT_CA_INC      4'ha
`define SLOT_CB_INC      4'hb
`define SLOT_CA_PH       4'hc
`define SLOT_CB_PH       4'hd
`define SLOT_VID_CFG     4'he
`define SLOT_VID_SCL     4'hf

// reset values and tick step
`define SREG_RST         32'h0000_0000
`define TICK_RST         32'h0000_0000
`define TICK_STEP        32'h0000_0001

`endif

// [rtl/cog_sreg_pkg.sv]
package cog_sreg_pkg;
  typedef logic [31:0] word_t;
  typedef logic [8:0]  reg_addr_t;
  typedef logic [3:0]  slot_t;
endpackage

// [rtl/sreg_shadow_mem.sv]
`timescale 1ns/100ps
// per-slot copy of the last instruction write; read data registered
module sreg_shadow_mem #(
  parameter int WIDTH     = 32,
  parameter int ADDR_BITS = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 wr_en,
  input  wire logic [ADDR_BITS-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]     wr_data,
  input  wire logic [ADDR_BITS-1:0] rd_addr,
  output logic      [WIDTH-1:0]     rd_data
);
  logic [WIDTH-1:0] mem_r [0:(1<<ADDR_BITS)-1];

  // storage has no reset; only rd_data is cleared
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // registered read returns the old word on a same-cycle write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule // sreg_shadow_mem

// [test/sreg_far_model.sv]
`timescale 1ns/100ps
// counter unit stand-in: phase accumulates increment while control is non-zero
module sreg_far_model (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire cog_sreg_pkg::word_t ctl_a,
  input  wire cog_sreg_pkg::word_t ctl_b,
  input  wire cog_sreg_pkg::word_t inc_a,
  input  wire cog_sreg_pkg::word_t inc_b,
  input  wire logic                ld_a,
  input  wire logic                ld_b,
  input  wire cog_sreg_pkg::word_t ld_val,
  output cog_sreg_pkg::word_t      ph_a,
  output cog_sreg_pkg::word_t      ph_b
);
  import cog_sreg_pkg::*;
  // a load wins over accumulation, so the written value is seen at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ph_a <= '0;
    else if (ld_a) ph_a <= ld_val;
    else if (ctl_a != '0) ph_a <= ph_a + inc_a;
  end
  // counter b behaves the same as counter a
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ph_b <= '0;
    else if (ld_b) ph_b <= ld_val;
    else if (ctl_b != '0) ph_b <= ph_b + inc_b;
  end
endmodule // sreg_far_model

// [test/cog_special_registers_tb_top.sv]
`timescale 1ns/100ps
`include "cog_sreg_regs.svh"
module cog_special_registers_tb_top;
  import cog_sreg_pkg::*;
  logic      clk = 1'b0;
  logic      rst_n = 1'b0;
  logic      wr_en = 1'b0;
  logic      ld = 1'b0;
  reg_addr_t sa = '0;
  reg_addr_t da = '0;
  reg_addr_t wa = '0;
  word_t     wd = '0;
  word_t     lv = '0;
  word_t     pin = '0;
  logic      sh, dh, pla, plb;
  word_t     sd, dd, po, poe, ca, cb, ia, ib, pha, phb, plv, vc, vs, tk, s, t, v;
  int        bad_count = 0;
  int        checks = 0;
  int        cyc = 0;
  int        ticks = 0;
  slot_t     pl [8] = '{4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'he, 4'hf};

  cog_special_registers u_dut (.clk(clk), .rst_n(rst_n), .src_addr(sa), .dst_addr(da),
    .wr_en(wr_en), .wr_addr(wa), .wr_data(wd), .src_hit(sh), .src_data(sd), .dst_hit(dh),
    .dst_data(dd), .launch_load(ld), .launch_value(lv), .pins_a_in(pin), .pins_a_out(po),
    .pins_a_oe(poe), .counter_a_control(ca), .counter_b_control(cb),
    .counter_a_increment(ia), .counter_b_increment(ib), .phase_a_live(pha),
    .phase_b_live(phb), .phase_a_load(pla), .phase_b_load(plb), .phase_load_value(plv),
    .video_config(vc), .video_scale(vs), .tick_count(tk));
  sreg_far_model u_far (.clk(clk), .rst_n(rst_n), .ctl_a(ca), .ctl_b(cb), .inc_a(ia),
    .inc_b(ib), .ld_a(pla), .ld_b(plb), .ld_val(plv), .ph_a(pha), .ph_b(phb));

  always #50 clk = ~clk;
  // edge count since release mirrors the tick; ceiling cuts a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (rst_n) ticks = ticks + 1;
    if (cyc == 2000) begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end

  task automatic chk(input string n, input word_t e, input word_t g);
    checks = checks + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input slot_t a, input word_t d);
    @(posedge clk);
    wr_en <= 1'b1;
    wa <= {`SREG_BASE, a};
    wd <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // source and destination ports read the same address together
  task automatic rd(input reg_addr_t a, output word_t rs, output word_t rt);
    @(posedge clk);
    sa <= a;
    da <= a;
    @(posedge clk);
    #1;
    rs = sd;
    rt = dd;
  endtask
  function automatic word_t out_of(input slot_t k);
    case (k)
      4'h4: return po;
      4'h6: return poe;
      4'h8: return ca;
      4'h9: return cb;
      4'ha: return ia;
      4'hb: return ib;
      4'he: return vc;
      default: return vs;
    endcase
  endfunction
  task automatic finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // every slot of the bank decodes; plain and reserved slots start clear
    for (int i = 0; i < 16; i++) begin
      rd({`SREG_BASE, 4'(i)}, s, t);
      chk("src_hit", 32'h1, {31'h0, sh});
      chk("dst_hit", 32'h1, {31'h0, dh});
      if (i inside {3, 4, 5, 6, 7, 8, 9, 10, 11, 14, 15}) chk("reset", `SREG_RST, s);
    end
    rd(9'h1ef, s, t);
    chk("miss_hit", 32'h0, {31'h0, sh});
    chk("miss_data", 32'h0, s);
    $display("test decode done");
    // whole-word writes land on outputs and read back both ways
    for (int i = 0; i < 8; i++) begin
      v = {pl[i], 28'h0c3_a5e1} ^ 32'(i);
      wr(pl[i], v);
      // source read right behind the write
      sa <= {`SREG_BASE, pl[i]};
      #1;
      chk("out", v, out_of(pl[i]));
      rd({`SREG_BASE, pl[i]}, s, t);
      chk("src", v, s);
      chk("dst", v, t);
    end
    $display("test plain done");
    // read-only slots ignore writes
    @(posedge clk);
    ld <= 1'b1;
    lv <= 32'h6b1e_0c40;
    @(posedge clk);
    ld <= 1'b0;
    // launch slot read right behind the load
    sa <= {`SREG_BASE, `SLOT_LAUNCH};
    wr(`SLOT_LAUNCH, 32'h94e1_f3bf);
    rd({`SREG_BASE, `SLOT_LAUNCH}, s, t);
    chk("launch", 32'h6b1e_0c40, s);
    wr(`SLOT_TICK, 32'hffff_0000);
    #1;
    chk("tick", 32'(ticks), tk);
    rd({`SREG_BASE, `SLOT_TICK}, s, t);
    chk("tick_src", 32'(ticks - 1), s);
    // pins change on an edge, then settle through the synchroniser
    @(posedge clk);
    pin <= 32'h8c01_7fe2;
    repeat (2) @(posedge clk);
    wr(`SLOT_A_IN, 32'h0000_ffff);
    rd({`SREG_BASE, `SLOT_A_IN}, s, t);
    chk("pins_in", 32'h8c01_7fe2, s);
    for (int i = 0; i < 3; i++) begin
      wr(slot_t'(3 + 2 * i), 32'hffff_ffff);
      rd({`SREG_BASE, 4'(3 + 2 * i)}, s, t);
      chk("port_b", 32'h0, s);
    end
    chk("pins_out", {4'h4, 28'h0c3_a5e1}, po);
    $display("test readonly done");
    // destination read of a phase gives the written word, not the live one
    for (int k = 0; k < 2; k++) begin
      wr(slot_t'(8 + k), 32'h1);
      wr(slot_t'(10 + k), 32'h3);
      wr(slot_t'(12 + k), 32'h0100_0000 + 32'(k));
      // destination read right behind the phase write
      da <= {`SREG_BASE, 4'(12 + k)};
      #1;
      chk("ph_load", 32'h1, {31'h0, k ? plb : pla});
      chk("ph_val", 32'h0100_0000 + 32'(k), plv);
      @(posedge clk);
      #1;
      chk("ph_pulse", 32'h0, {31'h0, k ? plb : pla});
      wr(slot_t'(8 + k), 32'h0);
      rd({`SREG_BASE, 4'(12 + k)}, s, t);
      chk("ph_src", k ? phb : pha, s);
      chk("ph_dst", 32'h0100_0000 + 32'(k), t);
    end
    $display("test phase done");
    finish_test();
  end
endmodule // cog_special_registers_tb_top
